//--- hw/bdc_pkg.sv
package bdc_pkg;
  localparam logic [10:0] A_TIME  = 11'h000;
  localparam logic [10:0] A_DATE  = 11'h001;
  localparam logic [10:0] A_CTRL  = 11'h002;
  localparam logic [10:0] A_STAT  = 11'h003;
  localparam logic [10:0] A_PRE   = 11'h004;
  localparam logic [10:0] A_WUT   = 11'h005;
  localparam logic [10:0] A_ALRA  = 11'h006;
  localparam logic [10:0] A_ALRB  = 11'h007;
  localparam logic [10:0] A_SSA   = 11'h008;
  localparam logic [10:0] A_SSB   = 11'h009;
  localparam logic [10:0] A_SSR   = 11'h00a;
  localparam logic [10:0] A_BKP   = 11'h010;
  localparam int          BKP_N   = 20;
  localparam int          SRAM_W  = 1024;
  localparam int          SRAM_B  = 10;
  localparam logic [6:0]  PRE_A_R = 7'h7f;
  localparam logic [12:0] PRE_S_R = 13'h00ff;
  localparam logic [6:0]  HSE_END = 7'h7f;
  localparam int          CAL_BIT = 5;
  localparam logic [7:0]  MAX59   = 8'h59;
  localparam logic [7:0]  HR23    = 8'h23;
  localparam logic [7:0]  HR12    = 8'h12;
  localparam logic [7:0]  HR11    = 8'h11;
  localparam logic [7:0]  ONE     = 8'h01;
  localparam logic [7:0]  FEB     = 8'h02;
  localparam logic [7:0]  DEC     = 8'h12;
  localparam logic [7:0]  YR99    = 8'h99;
  localparam logic [2:0]  SUNDAY  = 3'h7;
  localparam logic [2:0]  WSEL_S  = 3'h4;
  typedef enum logic [1:0] {SRC_LSE, SRC_LSI, SRC_HSE} bdc_src_t;
  typedef struct packed {
    logic       pm;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } bdc_time_t;
  typedef struct packed {
    logic [7:0] year;
    logic [2:0] wday;
    logic [7:0] mon;
    logic [7:0] date;
  } bdc_date_t;
  localparam bdc_time_t TIME_R = '{pm: 1'b0, hour: 8'h00, min: 8'h00, sec: 8'h00};
  localparam bdc_date_t DATE_R = '{year: 8'h00, wday: 3'h1, mon: 8'h01, date: 8'h01};
endpackage

//--- hw/bdc_top.sv
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - BCD calendar fields, 12 or 24 hour
// - Month end rollover, February 29 in leap years
// - Sub-second counter readable in binary
// - Alarm and periodic events wake system
// - Time base from LSE, LSI or HSE/128
// - Optional 512 Hz calibration output
// - Two independent alarm comparators
// - Per-field alarm masks
// - 16-bit auto-reload wakeup down-counter
// - 20-bit prescaler, default one second
// - Backup memory off until enabled
// - 80 bytes backup registers survive reset
// - Alarm registers hold subsecond to date
module bdc_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_lse_clk,
  input  wire logic        i_lsi_clk,
  input  wire logic        i_hse_clk,
  input  wire logic [10:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_alarm_a,
  output logic             o_alarm_b,
  output logic             o_wakeup,
  output logic             o_calib
);
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Source clocks sampled by three flops; a level is taken once stages two and three agree
  logic [2:0] s1_q, s2_q, s3_q, lvl_q;
  wire  [2:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  wire  [2:0] rise  = lvl_d & ~lvl_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      s1_q  <= {i_hse_clk, i_lsi_clk, i_lse_clk};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Control and configuration
  logic [31:0] ctrl_q;
  logic [6:0]  pre_a_q;
  logic [12:0] pre_s_q;
  logic [15:0] wut_rl_q;
  logic [31:0] alr_q [2];
  logic [31:0] ssa_q [2];
  logic [2:0]  stat_q;
  wire        fmt12    = ctrl_q[0];
  wire        bsram_en = ctrl_q[10];
  wire        cal_en   = ctrl_q[9];
  wire [2:0]  wsel     = ctrl_q[8:6];
  wire [2:0]  evt_en   = ctrl_q[5:3];
  wire bdc_pkg::bdc_src_t src = bdc_pkg::bdc_src_t'(ctrl_q[2:1]);

  // HSE is divided by 128 before it may serve as time base
  logic [6:0] hse_div_q;
  wire hse_tick = rise[2] & (hse_div_q == bdc_pkg::HSE_END);
  wire rtc_tick = (src == bdc_pkg::SRC_LSE) ? rise[0] :
                  (src == bdc_pkg::SRC_LSI) ? rise[1] :
                  (src == bdc_pkg::SRC_HSE) ? hse_tick : 1'b0;

  // Prescaler: 7-bit asynchronous stage then 13-bit synchronous stage
  logic [6:0]  a_q;
  logic [12:0] ss_q;
  wire a_tick = rtc_tick & (a_q == pre_a_q);
  wire s_tick = a_tick & (ss_q == pre_s_q);

  // Register decode
  wire w_time = i_wr & (i_addr == bdc_pkg::A_TIME);
  wire w_date = i_wr & (i_addr == bdc_pkg::A_DATE);
  wire w_ctrl = i_wr & (i_addr == bdc_pkg::A_CTRL);
  wire w_stat = i_wr & (i_addr == bdc_pkg::A_STAT);
  wire w_pre  = i_wr & (i_addr == bdc_pkg::A_PRE);
  wire w_wut  = i_wr & (i_addr == bdc_pkg::A_WUT);
  wire [10:0] bkp_off = i_addr - bdc_pkg::A_BKP;
  wire is_bkp  = (i_addr >= bdc_pkg::A_BKP) & (bkp_off < 11'(bdc_pkg::BKP_N));
  wire is_sram = i_addr[bdc_pkg::SRAM_B];

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q    <= 32'h0000_0000;
      pre_a_q   <= bdc_pkg::PRE_A_R;
      pre_s_q   <= bdc_pkg::PRE_S_R;
      wut_rl_q  <= 16'hffff;
      hse_div_q <= 7'h00;
      a_q       <= 7'h00;
      ss_q      <= 13'h0000;
    end else begin
      if (w_ctrl) ctrl_q <= i_wdata;
      if (w_pre) begin
        pre_s_q <= i_wdata[12:0];
        pre_a_q <= i_wdata[22:16];
      end
      if (w_wut) wut_rl_q <= i_wdata[15:0];
      if (rise[2]) hse_div_q <= hse_div_q + 7'h01;
      if (w_pre) begin
        a_q  <= 7'h00;
        ss_q <= 13'h0000;
      end else if (rtc_tick) begin
        a_q <= a_tick ? 7'h00 : a_q + 7'h01;
        if (a_tick) ss_q <= s_tick ? 13'h0000 : ss_q + 13'h0001;
      end
    end
  end

  // Calibration output, 512 Hz when the asynchronous stage divides by 128
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) o_calib <= 1'b0;
    else o_calib <= cal_en & a_q[bdc_pkg::CAL_BIT];
  end

  // Calendar
  bdc_pkg::bdc_time_t tm_q, tm_d;
  bdc_pkg::bdc_date_t dt_q, dt_d;
  wire sec_wrap = tm_q.sec == bdc_pkg::MAX59;
  wire min_wrap = tm_q.min == bdc_pkg::MAX59;
  wire hr_last  = fmt12 ? (tm_q.hour == bdc_pkg::HR11) & tm_q.pm : tm_q.hour == bdc_pkg::HR23;
  wire day_end  = sec_wrap & min_wrap & hr_last;
  wire leap = dt_q.year[4] ? (dt_q.year[3:0] == 4'h2) | (dt_q.year[3:0] == 4'h6) :
              (dt_q.year[3:0] == 4'h0) | (dt_q.year[3:0] == 4'h4) | (dt_q.year[3:0] == 4'h8);
  wire short30 = (dt_q.mon == 8'h04) | (dt_q.mon == 8'h06) | (dt_q.mon == 8'h09) | (dt_q.mon == 8'h11);
  wire [7:0] mdays = (dt_q.mon == bdc_pkg::FEB) ? (leap ? 8'h29 : 8'h28) : short30 ? 8'h30 : 8'h31;
  wire mon_end = dt_q.date == mdays;

  always_comb begin
    tm_d     = tm_q;
    tm_d.sec = sec_wrap ? 8'h00 : bcd_inc(tm_q.sec);
    if (sec_wrap) tm_d.min = min_wrap ? 8'h00 : bcd_inc(tm_q.min);
    if (sec_wrap & min_wrap) begin
      if (!fmt12) begin
        tm_d.hour = hr_last ? 8'h00 : bcd_inc(tm_q.hour);
      end else if (tm_q.hour == bdc_pkg::HR12) begin
        tm_d.hour = bdc_pkg::ONE;
      end else begin
        tm_d.hour = bcd_inc(tm_q.hour);
        if (tm_q.hour == bdc_pkg::HR11) tm_d.pm = ~tm_q.pm;
      end
    end
    dt_d = dt_q;
    if (day_end) begin
      dt_d.wday = (dt_q.wday == bdc_pkg::SUNDAY) ? 3'h1 : dt_q.wday + 3'h1;
      dt_d.date = mon_end ? bdc_pkg::ONE : bcd_inc(dt_q.date);
      if (mon_end) begin
        dt_d.mon = (dt_q.mon == bdc_pkg::DEC) ? bdc_pkg::ONE : bcd_inc(dt_q.mon);
        if (dt_q.mon == bdc_pkg::DEC) dt_d.year = (dt_q.year == bdc_pkg::YR99) ? 8'h00 : bcd_inc(dt_q.year);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tm_q <= bdc_pkg::TIME_R;
      dt_q <= bdc_pkg::DATE_R;
    end else begin
      if (w_time) tm_q <= {i_wdata[22], 2'b00, i_wdata[21:16], 1'b0, i_wdata[14:8], 1'b0, i_wdata[6:0]};
      else if (s_tick) tm_q <= tm_d;
      if (w_date) dt_q <= {i_wdata[23:16], i_wdata[15:13], 3'b000, i_wdata[12:8], 2'b00, i_wdata[5:0]};
      else if (s_tick) dt_q <= dt_d;
    end
  end

  // Two alarm comparators; a set mask bit removes its field from the match
  logic [1:0] hit;
  for (genvar k = 0; k < 2; k++) begin : g_alr
    wire [31:0] r   = alr_q[k];
    wire [31:0] s   = ssa_q[k];
    wire [7:0]  dwf = r[30] ? {5'h00, dt_q.wday} : dt_q.date;
    assign hit[k] = a_tick & evt_en[k]
      & (r[7]  | (r[6:0] == tm_q.sec[6:0]))
      & (r[15] | (r[14:8] == tm_q.min[6:0]))
      & (r[23] | ((r[21:16] == tm_q.hour[5:0]) & (r[22] == tm_q.pm)))
      & (r[31] | (r[29:24] == dwf[5:0]))
      & (s[31] | (s[12:0] == ss_q));
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        alr_q[k] <= 32'h0000_0000;
        ssa_q[k] <= 32'h8000_0000;
      end else begin
        if (i_wr & (i_addr == bdc_pkg::A_ALRA + 11'(k))) alr_q[k] <= i_wdata;
        if (i_wr & (i_addr == bdc_pkg::A_SSA + 11'(k))) ssa_q[k] <= i_wdata;
      end
    end
  end

  // Wakeup timer; resolution 0..3 divides the time base by 16, 8, 4, 2, 4 and up use the seconds tick
  logic [3:0]  wd_q;
  logic [15:0] wut_q;
  wire [3:0] wd_mask = 4'hf >> wsel[1:0];
  wire wut_tick = wsel[2] ? s_tick : rtc_tick & ((wd_q & wd_mask) == wd_mask);
  wire wut_hit  = evt_en[2] & wut_tick & (wut_q == 16'h0000);
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_q  <= 4'h0;
      wut_q <= 16'hffff;
    end else begin
      if (rtc_tick) wd_q <= wd_q + 4'h1;
      if (!evt_en[2]) wut_q <= wut_rl_q;
      else if (wut_tick) wut_q <= (wut_q == 16'h0000) ? wut_rl_q : wut_q - 16'h0001;
    end
  end

  // Sticky event flags: a write of one clears, but a new event in the same cycle wins
  wire [2:0] evt = {wut_hit, hit};
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) stat_q <= 3'h0;
    else stat_q <= evt | (stat_q & ~(w_stat ? i_wdata[2:0] : 3'h0));
  end
  assign o_alarm_a = stat_q[0];
  assign o_alarm_b = stat_q[1];
  assign o_wakeup  = stat_q[2];

  // Backup registers and backup memory hold no reset so they survive system resets
  logic [31:0] bkp_q  [bdc_pkg::BKP_N];
  logic [31:0] sram_q [bdc_pkg::SRAM_W];
  always_ff @(posedge i_core_clk) begin
    if (i_wr & is_bkp) bkp_q[bkp_off[4:0]] <= i_wdata;
    if (i_wr & is_sram & bsram_en) sram_q[i_addr[9:0]] <= i_wdata;
  end

  logic [31:0] rd_val;
  always_comb begin
    if (is_sram) rd_val = bsram_en ? sram_q[i_addr[9:0]] : 32'h0000_0000;
    else if (is_bkp) rd_val = bkp_q[bkp_off[4:0]];
    else if (i_addr == bdc_pkg::A_TIME) rd_val = {9'h000, tm_q.pm, tm_q.hour[5:0], 1'b0, tm_q.min[6:0], 1'b0, tm_q.sec[6:0]};
    else if (i_addr == bdc_pkg::A_DATE) rd_val = {8'h00, dt_q.year, dt_q.wday, dt_q.mon[4:0], 2'b00, dt_q.date[5:0]};
    else if (i_addr == bdc_pkg::A_CTRL) rd_val = ctrl_q;
    else if (i_addr == bdc_pkg::A_STAT) rd_val = {29'h0000_0000, stat_q};
    else if (i_addr == bdc_pkg::A_PRE)  rd_val = {9'h000, pre_a_q, 3'h0, pre_s_q};
    else if (i_addr == bdc_pkg::A_WUT)  rd_val = {16'h0000, wut_rl_q};
    else if (i_addr == bdc_pkg::A_ALRA) rd_val = alr_q[0];
    else if (i_addr == bdc_pkg::A_ALRB) rd_val = alr_q[1];
    else if (i_addr == bdc_pkg::A_SSA)  rd_val = ssa_q[0];
    else if (i_addr == bdc_pkg::A_SSB)  rd_val = ssa_q[1];
    else if (i_addr == bdc_pkg::A_SSR)  rd_val = {19'h0_0000, ss_q};
    else rd_val = 32'h0000_0000;
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= 32'h0000_0000;
    else o_rdata <= i_rd ? rd_val : 32'h0000_0000;
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sec_carry_a: assert property (s_tick && !w_time && sec_wrap |=> tm_q.sec == 8'h00 && tm_q.min != $past(tm_q.min))
    else $error("seconds did not carry");
  hour_wrap_a: assert property (s_tick && !w_time && !fmt12 && day_end |=> tm_q.hour == 8'h00)
    else $error("24h day wrap wrong");
  feb_end_a: assert property (s_tick && !w_date && day_end && dt_q.mon == 8'h02 && dt_q.date == 8'h28 && !leap
    |=> dt_q.date == 8'h01 && dt_q.mon == 8'h03)
    else $error("february rollover wrong");
  pre_wrap_a: assert property (s_tick && !w_pre |=> ss_q == 13'h0000 && a_q == 7'h00)
    else $error("prescaler did not wrap");
  wut_event_a: assert property (wut_hit |=> stat_q[2] [*2])
    else $error("wakeup flag not held");
  alarm_cause_a: assert property ($rose(stat_q[0]) |-> $past(hit[0]))
    else $error("alarm A without match");
  sram_off_a: assert property (i_rd && is_sram && !bsram_en |=> o_rdata == 32'h0000_0000)
    else $error("backup memory readable while off");
  calib_off_a: assert property (!cal_en |=> !o_calib)
    else $error("calibration output without enable");
  min_carry_a: assert property (s_tick && !w_time && sec_wrap && min_wrap |=> tm_q.min == 8'h00)
    else $error("minutes did not carry");
  noon_wrap_a: assert property (s_tick && !w_time && fmt12 && sec_wrap && min_wrap && tm_q.hour == bdc_pkg::HR12
    |=> tm_q.hour == bdc_pkg::ONE) else $error("12h hour wrap wrong");
  wday_wrap_a: assert property (s_tick && !w_date && day_end && dt_q.wday == bdc_pkg::SUNDAY |=> dt_q.wday == 3'h1)
    else $error("weekday wrap wrong");
  sub_count_a: assert property (a_tick && !s_tick && !w_pre |=> ss_q == $past(ss_q) + 13'h0001)
    else $error("subsecond count wrong");
  src_none_a: assert property (ctrl_q[2:1] == 2'b11 |-> !rtc_tick)
    else $error("time base ticks with no source");
  wut_reload_a: assert property (wut_hit |=> wut_q == $past(wut_rl_q))
    else $error("wakeup counter did not reload");
  wut_count_a: assert property (evt_en[2] && wut_tick && wut_q != 16'h0000 |=> wut_q == $past(wut_q) - 16'h0001)
    else $error("wakeup counter did not count down");
  alarm_b_cause_a: assert property ($rose(stat_q[1]) |-> $past(hit[1]))
    else $error("alarm B without match");
  flag_hold_a: assert property (stat_q[2] && !w_stat |=> stat_q[2])
    else $error("wakeup flag lost");
  // Every field masked must match on each enabled prescaler tick
  mask_all_a: assert property (a_tick && evt_en[0] && alr_q[0][31] && alr_q[0][23] && alr_q[0][15]
    && alr_q[0][7] && ssa_q[0][31] |-> hit[0]) else $error("masked alarm did not match");
  day_cover_c: cover property (s_tick && day_end && fmt12);
  month_cover_c: cover property (s_tick && day_end && mon_end);
  alarm_cover_c: cover property (hit[1] ##1 stat_q[1]);
  wut_cover_c: cover property (wut_hit);
endmodule

//--- test/bdc_tb.sv
`timescale 1ns/1ns
module tb;
  logic        clk   = 1'b0;
  logic        rstn  = 1'b0;
  logic        lse   = 1'b0;
  logic        lsi   = 1'b0;
  logic        hse   = 1'b0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [10:0] addr  = 11'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, t, d, got;
  logic [32:0] e;
  logic        alm_a, alm_b, wake, calib, ok;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n, c;
  logic [31:0] bk [20];
  logic [33:0] cs [10];
  always #10 clk = ~clk;
  // Sources run far faster than real so a second lasts a few cycles
  always #100 lse = ~lse;
  always #130 lsi = ~lsi;
  always #50 hse = ~hse;
  bdc_top bdc_top_inst (.i_core_clk(clk), .i_rstn(rstn), .i_lse_clk(lse), .i_lsi_clk(lsi), .i_hse_clk(hse),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_alarm_a(alm_a),
    .o_alarm_b(alm_b), .o_wakeup(wake), .o_calib(calib));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr_reg(input logic [10:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [10:0] a, output logic [31:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // Reads TIME until it differs from s; cnt gives the reads spent, two cycles each
  task automatic poll(input logic [31:0] s, input int m, output logic [31:0] v, output int cnt);
    cnt = 0;
    v = s;
    while (cnt < m && v === s) begin
      rd_reg(bdc_pkg::A_TIME, v);
      cnt++;
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  function automatic logic [31:0] nxt_date(input logic [31:0] x);
    logic [7:0] y, m, dt, last;
    y = x[23:16];
    m = {3'h0, x[12:8]};
    dt = {2'h0, x[5:0]};
    last = (m == 8'h02) ? ((((y[7:4] * 10 + y[3:0]) % 4) == 0) ? 8'h29 : 8'h28) :
           (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) ? 8'h30 : 8'h31;
    if (dt == last) begin
      dt = 8'h01;
      y = (m == 8'h12) ? ((y == 8'h99) ? 8'h00 : inc(y)) : y;
      m = (m == 8'h12) ? 8'h01 : inc(m);
    end else dt = inc(dt);
    return {8'h00, y, (x[15:13] == 3'h7) ? 3'h1 : x[15:13] + 3'h1, m[4:0], 2'h0, dt[5:0]};
  endfunction
  // Next time after hh:59:59; bit 32 tells whether the day ended
  function automatic logic [32:0] nxt_time(input logic [31:0] x, input logic h12);
    logic [7:0] h;
    logic       pm;
    h = {2'h0, x[21:16]};
    pm = x[22];
    if (h12) begin
      pm = (h == 8'h11) ? ~pm : pm;
      h = (h == 8'h12) ? 8'h01 : inc(h);
    end else h = (h == 8'h23) ? 8'h00 : inc(h);
    return {(h12 ? (h == 8'h12 && !pm) : (h == 8'h00)), 9'h000, pm && h12, h[5:0], 16'h0000};
  endfunction
  initial begin
    #1_500_000;
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(7));
    cs = '{34'h0_2301_0228, 34'h0_2304_0228, 34'h0_2304_0229, 34'h0_2300_0228, 34'h0_2399_1231,
           34'h0_2321_1130, 34'h0_0921_0131, 34'h3_1121_0930, 34'h2_1121_0930, 34'h2_1221_0615};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(bdc_pkg::A_DATE, got);
    chk(got, 32'h0000_2101);
    @(posedge clk);
    #1 chk(rdata, 32'h0000_0000);
    rd_reg(bdc_pkg::A_PRE, got);
    chk(got, 32'h007f_00ff);
    rd_reg(bdc_pkg::A_SSA, got);
    chk(got, 32'h8000_0000);
    wr_reg(11'h00b, 32'hffff_ffff);
    rd_reg(11'h00b, got);
    chk(got, 32'h0000_0000);
    $display("test reset values done");
    for (int i = 0; i < 20; i++) begin
      bk[i] = $urandom;
      wr_reg(bdc_pkg::A_BKP + 11'(i), bk[i]);
    end
    c = $urandom_range(1023, 0);
    wr_reg(11'h400 + 11'(c), 32'hdead_0001);
    rd_reg(11'h400 + 11'(c), got);
    chk(got, 32'h0000_0000);
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0400);
    wr_reg(11'h400 + 11'(c), bk[3]);
    rd_reg(11'h400 + 11'(c), got);
    chk(got, bk[3]);
    // Mid-run reset: backup registers must ride through it; backup memory reads zero once reset disables it
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      rd_reg(bdc_pkg::A_BKP + 11'(i), got);
      chk(got, bk[i]);
    end
    rd_reg(11'h400 + 11'(c), got);
    chk(got, 32'h0000_0000);
    $display("test backup storage done");
    wr_reg(bdc_pkg::A_PRE, 32'h0000_0001);
    for (int k = 0; k < 10; k++) begin
      wr_reg(bdc_pkg::A_CTRL, {31'h0, cs[k][33]});
      d = {8'h00, cs[k][23:16], 3'($urandom_range(7, 1)), cs[k][12:8], 2'h0, cs[k][5:0]};
      t = {9'h000, cs[k][32], cs[k][29:24], 16'h5959};
      wr_reg(bdc_pkg::A_DATE, d);
      wr_reg(bdc_pkg::A_TIME, t);
      poll(t, 60, got, n);
      e = nxt_time(t, cs[k][33]);
      chk(got, e[31:0]);
      rd_reg(bdc_pkg::A_DATE, got);
      chk(got, e[32] ? nxt_date(d) : d);
    end
    $display("test calendar rollover done");
    for (int s = 0; s < 4; s++) begin
      wr_reg(bdc_pkg::A_CTRL, 32'(s) << 1);
      wr_reg(bdc_pkg::A_TIME, 32'h0000_0000);
      poll(32'h0000_0000, (s == 3) ? 150 : 1000, got, n);
      chk(got, (s == 3) ? 32'h0000_0000 : 32'h0000_0001);
      if (s == 2) begin
        poll(got, 1000, got, n);
        chk({31'h0, n >= 635 && n <= 645}, 32'h0000_0001);
      end
    end
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0000);
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(bdc_pkg::A_SSR, got);
      ok = ok && (got <= 32'h0000_0001);
    end
    chk({31'h0, ok}, 32'h0000_0001);
    $display("test sources done");
    wr_reg(bdc_pkg::A_ALRA, 32'h8080_8005);
    wr_reg(bdc_pkg::A_ALRB, 32'h8080_8030);
    wr_reg(bdc_pkg::A_STAT, 32'h0000_0007);
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0018);
    wr_reg(bdc_pkg::A_TIME, 32'h0000_0002);
    for (n = 0; n < 200 && alm_a !== 1'b1; n++) @(posedge clk);
    #1 chk({31'h0, alm_a}, 32'h0000_0001);
    chk({31'h0, alm_b}, 32'h0000_0000);
    rd_reg(bdc_pkg::A_STAT, got);
    chk(got, 32'h0000_0001);
    repeat (30) @(posedge clk);
    wr_reg(bdc_pkg::A_ALRA, 32'h8080_4505);
    wr_reg(bdc_pkg::A_STAT, 32'h0000_0001);
    wr_reg(bdc_pkg::A_TIME, 32'h0000_0002);
    repeat (150) @(posedge clk);
    #1 chk({31'h0, alm_a}, 32'h0000_0000);
    wr_reg(bdc_pkg::A_ALRB, 32'h8080_8080);
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0010);
    repeat (30) @(posedge clk);
    #1 chk({31'h0, alm_b}, 32'h0000_0001);
    $display("test alarms done");
    wr_reg(bdc_pkg::A_WUT, 32'h0000_0003);
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0020);
    #1 chk({31'h0, wake}, 32'h0000_0000);
    for (n = 0; n < 3000 && wake !== 1'b1; n++) @(posedge clk);
    #1 chk({31'h0, wake}, 32'h0000_0001);
    $display("test wakeup done");
    wr_reg(bdc_pkg::A_PRE, 32'h007f_00ff);
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0200);
    c = 0;
    ok = calib;
    // 150 source edges pass; the output flips every 32 of them
    repeat (1500) begin
      @(posedge clk);
      #1 c = c + ((calib !== ok) ? 1 : 0);
      ok = calib;
    end
    chk({31'h0, c >= 4 && c <= 5}, 32'h0000_0001);
    wr_reg(bdc_pkg::A_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    c = 0;
    repeat (400) begin
      @(posedge clk);
      #1 c = c + ((calib !== 1'b0) ? 1 : 0);
    end
    chk(32'(c), 32'h0000_0000);
    $display("test calibration output done");
    complete_run();
  end
endmodule
